/* sfm_field_model.sv */
/* field model: one signal head on channel 1, others dark
   aspect is changed by the bench just after a core_clk edge */
`timescale 1ns/1ps
module sfm_field_model
  import sfm_pkg::*;
(
  input  wire logic [2:0]     aspect,
  output logic      [NCH-1:0] greenIn,
  output logic      [NCH-1:0] yellowIn,
  output logic      [NCH-1:0] redIn
);
  // lamps follow {red, yellow, green}; no preemption path exists
  always_comb
  begin
    greenIn  = NCH'(aspect[0]);
    yellowIn = NCH'(aspect[1]);
    redIn    = NCH'(aspect[2]);
  end
endmodule

/* sfm_input_filter.sv */
/*
  Shared constants of the signal fault monitor, and the input conditioner
  that brings every pin-level input into the core_clk domain.
  Assumes all inputs may change at any time relative to core_clk.
*/
package sfm_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

  // channel geometry
  localparam int NCH   = 16;
  localparam int CFG_W = 32;
  localparam int IN_W  = 3 * NCH + 1 + 1 + NCH + 1 + 3 + 1 + 1 + CFG_W + 1 + 1 + 1 + 1;

  // positions inside the conditioned input vector
  localparam int POS_GRN    = 0;
  localparam int POS_YEL    = 16;
  localparam int POS_RED    = 32;
  localparam int POS_REDEN  = 48;
  localparam int POS_INHIB  = 49;
  localparam int POS_CHSW   = 50;
  localparam int POS_GYEN   = 66;
  localparam int POS_YSEL   = 67;
  localparam int POS_RPDIS  = 70;
  localparam int POS_CFGEN  = 71;
  localparam int POS_CFG    = 72;
  localparam int POS_CARD   = 104;
  localparam int POS_BTN    = 105;
  localparam int POS_EXTRST = 106;
  localparam int POS_ACGOOD = 107;

  // timing figures in milliseconds, converted to 1 ms ticks
  localparam int unsigned DUAL_MIN_MS   = 250;
  localparam int unsigned DUAL_MAX_MS   = 500;
  localparam logic [12:0] DUAL_TRIP     = 13'((DUAL_MIN_MS + DUAL_MAX_MS) / 2 / TICK_MS);
  localparam int unsigned YEL_BASE_MS   = 2700;
  localparam int unsigned YEL_STEP_MS   = 200;
  localparam logic [12:0] YEL_BASE      = 13'(YEL_BASE_MS / TICK_MS);
  localparam logic [12:0] YEL_STEP      = 13'(YEL_STEP_MS / TICK_MS);
  localparam int unsigned CFG_HOLD_MS   = 5000;
  localparam logic [12:0] CFG_HOLD      = 13'(CFG_HOLD_MS / TICK_MS);
  localparam int unsigned CFG_PERIOD_MS = 1000;
  localparam logic [12:0] CFG_PERIOD    = 13'(CFG_PERIOD_MS / TICK_MS);
  localparam int unsigned EXIT_LEAD_MS  = 250;
  localparam logic [12:0] EXIT_LEAD     = 13'(EXIT_LEAD_MS / TICK_MS);
  localparam int unsigned FLT_SHOW_MS   = 2000;
  localparam int unsigned FLD_SHOW_MS   = 6000;
  localparam logic [12:0] FLT_SHOW      = 13'(FLT_SHOW_MS / TICK_MS);
  localparam logic [12:0] DISP_CYCLE    = 13'((FLT_SHOW_MS + FLD_SHOW_MS) / TICK_MS);
  localparam int unsigned FLASH_HALF_MS = 125;
  localparam logic [12:0] FLASH_HALF    = 13'(FLASH_HALF_MS / TICK_MS);
  localparam int unsigned RP_WINDOW_MS  = 2000;
  localparam logic [12:0] RP_WINDOW     = 13'(RP_WINDOW_MS / TICK_MS);
  localparam logic [2:0]  RP_PULSES     = 3'h3;
  localparam logic [1:0]  HIST_LAST     = 2'h2;
  localparam logic [3:0]  BLINK_LAST    = 4'hf;

  // relay and stop-time sequencing
  typedef enum logic [2:0] {
    SFM_FLASH = 3'b001,
    SFM_EXIT  = 3'b010,
    SFM_RUN   = 3'b100
  } sfm_relay_t;

  // sequence tracking per channel
  typedef enum logic [2:0] {
    SFM_SEQ_IDLE  = 3'b001,
    SFM_SEQ_GREEN = 3'b010,
    SFM_SEQ_YEL   = 3'b100
  } sfm_seq_t;
endpackage

`timescale 1ns/1ps

module sfm_input_filter
  import sfm_pkg::*;
(
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // raw and conditioned inputs
  input  wire logic [IN_W-1:0] rawIn,
  output logic      [IN_W-1:0] cleanOut
);
  logic [IN_W-1:0] stage1_r;
  logic [IN_W-1:0] stage2_r;
  logic [IN_W-1:0] stage3_r;

  // three-flop chain; the first flop is only read by the second
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end
    else
    begin
      stage1_r <= rawIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // a bit changes only once the second and third stages agree
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cleanOut <= '0;
    else
      for (int i = 0; i < IN_W; i++)
        if (stage2_r[i] == stage3_r[i])
          cleanOut[i] <= stage3_r[i];
  end
endmodule

/* sfm_monitor_props.sv */
/* checker: exit flash order, overlap timing, latched flash, log word
   bound to the monitor top; TICK_CYCLES as handed to the monitor */
`timescale 1ns/1ps
module sfm_monitor_props
  import sfm_pkg::*;
#(parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF)
(
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire logic [NCH-1:0]   greenIn,
  input wire logic [NCH-1:0]   yellowIn,
  input wire logic [NCH-1:0]   redIn,
  input wire logic             recurrentPulseDisable,
  input wire logic             outputRelay,
  input wire logic             stopTime,
  input wire logic             colour_overlap_fault,
  input wire logic             sequenceFaultLed,
  input wire logic [CFG_W-1:0] configLogWord,
  input wire logic             configLogStrobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] lowCnt_r;
  logic [31:0] ovlCnt_r;
  logic        anyDual;
  // two colours lit at once on any channel
  assign anyDual = |((greenIn & yellowIn) | (greenIn & redIn) | (yellowIn & redIn));
  // cycles since stop-time dropped
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) lowCnt_r <= '0;
    else lowCnt_r <= stopTime ? '0 : lowCnt_r + 32'h1;
  // cycles of unbroken overlap
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) ovlCnt_r <= '0;
    else ovlCnt_r <= anyDual ? ovlCnt_r + 32'h1 : '0;
  sequence s_stopDrop; $fell(stopTime); endsequence
  sequence s_relayUp; $rose(outputRelay); endsequence
  property p_relayStop; outputRelay |-> !stopTime; endproperty
  a_relayStop: assert property (p_relayStop) else $error("relay on with stop");
  property p_exitMin; s_relayUp |-> lowCnt_r >= 200 * TICK_CYCLES; endproperty
  a_exitMin: assert property (p_exitMin) else $error("exit lead short");
  property p_exitMax; s_relayUp |-> lowCnt_r <= 300 * TICK_CYCLES; endproperty
  a_exitMax: assert property (p_exitMax) else $error("exit lead long");
  property p_ovlFlash; colour_overlap_fault [*2] |-> stopTime && !outputRelay; endproperty
  a_ovlFlash: assert property (p_ovlFlash) else $error("overlap not in flash");
  property p_seqFlash; sequenceFaultLed [*2] |-> stopTime && !outputRelay; endproperty
  a_seqFlash: assert property (p_seqFlash) else $error("sequence not in flash");
  property p_stopClear; s_stopDrop |-> !colour_overlap_fault && !sequenceFaultLed; endproperty
  a_stopClear: assert property (p_stopClear) else $error("stop dropped on fault");
  property p_ovlMin;
    $rose(colour_overlap_fault) && recurrentPulseDisable |-> ovlCnt_r >= 250 * TICK_CYCLES;
  endproperty
  a_ovlMin: assert property (p_ovlMin) else $error("overlap tripped early");
  property p_logWord; $changed(configLogWord) |-> configLogStrobe; endproperty
  a_logWord: assert property (p_logWord) else $error("log word without strobe");
endmodule

/* sfm_signal_fault_monitor.sv */
/*
  Fault detection, relay sequencing and channel display of a sixteen
  channel signal fault monitor: colour overlap, short yellow, recurrent
  pulse, configuration change, card ajar, exit flash and fault review.
  Assumes field inputs arrive already sensed as logic levels, a single
  125 MHz core_clk, and that history survives line loss while core power
  (reset_n) is held.
*/
`timescale 1ns/1ps

module sfm_signal_fault_monitor
  import sfm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // clock and reset
  core_clk,
  reset_n,
  // sensed field inputs
  greenIn,
  yellowIn,
  redIn,
  // control inputs
  redEnableIn,
  external_inhibit_input,
  acLineGood,
  // circuit board switches
  channel_check_switch,
  green_yellow_overlap_enable,
  yellow_clearance_select,
  recurrentPulseDisable,
  configFaultEnable,
  configSettings,
  // program card and reset commands
  cardSeated,
  resetButton,
  externalResetIn,
  // cabinet outputs
  outputRelay,
  stopTime,
  // indicators
  colour_overlap_fault,
  sequenceFaultLed,
  recurrent_pulse_detect,
  program_card_ajar,
  dispGreen,
  dispYellow,
  dispRed,
  // configuration log
  configLogStrobe,
  configLogWord
);
  input  wire logic             core_clk;
  input  wire logic             reset_n;
  input  wire logic [NCH-1:0]   greenIn;
  input  wire logic [NCH-1:0]   yellowIn;
  input  wire logic [NCH-1:0]   redIn;
  input  wire logic             redEnableIn;
  input  wire logic             external_inhibit_input;
  input  wire logic             acLineGood;
  input  wire logic [NCH-1:0]   channel_check_switch;
  input  wire logic             green_yellow_overlap_enable;
  input  wire logic [2:0]       yellow_clearance_select;
  input  wire logic             recurrentPulseDisable;
  input  wire logic             configFaultEnable;
  input  wire logic [CFG_W-1:0] configSettings;
  input  wire logic             cardSeated;
  input  wire logic             resetButton;
  input  wire logic             externalResetIn;
  output logic                  outputRelay;
  output logic                  stopTime;
  output logic                  colour_overlap_fault;
  output logic                  sequenceFaultLed;
  output logic                  recurrent_pulse_detect;
  output logic                  program_card_ajar;
  output logic      [NCH-1:0]   dispGreen;
  output logic      [NCH-1:0]   dispYellow;
  output logic      [NCH-1:0]   dispRed;
  output logic                  configLogStrobe;
  output logic      [CFG_W-1:0] configLogWord;

  // clearance interval in ticks for a switch setting
  function automatic logic [12:0] yelClear(input logic [2:0] sel);
    yelClear = 13'(YEL_BASE + YEL_STEP * {10'h000, sel});
  endfunction

  // saturating tick counter step
  function automatic logic [12:0] tickUp(input logic [12:0] v, input logic t);
    tickUp = (t && v != 13'h1fff) ? 13'(v + 13'h0001) : v;
  endfunction

  logic [IN_W-1:0]  cleanIn;
  logic [NCH-1:0]   grn, yel, red, chSw;
  logic             redEn, inhibit, gyEn, rpDis, cfgEn, card, acGood;
  logic [2:0]       ySel;
  logic [CFG_W-1:0] cfgNow;
  logic             rstLevel, rstLevel_r, resetCmd;
  logic [31:0]      tickCnt_r;
  logic             tick_r;

  // every pin input passes the conditioner
  sfm_input_filter uFilter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .rawIn    ({acLineGood, externalResetIn, resetButton, cardSeated, configSettings,
                configFaultEnable, recurrentPulseDisable, yellow_clearance_select,
                green_yellow_overlap_enable, channel_check_switch, external_inhibit_input,
                redEnableIn, redIn, yellowIn, greenIn}),
    .cleanOut (cleanIn)
  );

  // split the conditioned vector
  assign grn      = cleanIn[POS_GRN +: NCH];
  assign yel      = cleanIn[POS_YEL +: NCH];
  assign red      = cleanIn[POS_RED +: NCH];
  assign redEn    = cleanIn[POS_REDEN];
  assign inhibit  = cleanIn[POS_INHIB];
  assign chSw     = cleanIn[POS_CHSW +: NCH];
  assign gyEn     = cleanIn[POS_GYEN];
  assign ySel     = cleanIn[POS_YSEL +: 3];
  assign rpDis    = cleanIn[POS_RPDIS];
  assign cfgEn    = cleanIn[POS_CFGEN];
  assign cfgNow   = cleanIn[POS_CFG +: CFG_W];
  assign card     = cleanIn[POS_CARD];
  assign acGood   = cleanIn[POS_ACGOOD];
  assign rstLevel = cleanIn[POS_BTN] | cleanIn[POS_EXTRST];
  assign resetCmd = rstLevel & ~rstLevel_r;

  // 1 ms time base and reset command edge
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tickCnt_r  <= 32'h0;
      tick_r     <= 1'b0;
      rstLevel_r <= 1'b0;
    end
    else
    begin
      tick_r     <= (tickCnt_r == TICK_CYCLES - 1);
      tickCnt_r  <= (tickCnt_r == TICK_CYCLES - 1) ? 32'h0 : tickCnt_r + 32'h1;
      rstLevel_r <= rstLevel;
    end
  end

  // overlap condition per channel
  logic [NCH-1:0] dualCond, dualPrev_r, dualOnset;
  logic [12:0]    dualCnt_r [NCH];
  logic [NCH-1:0] overlapCh_r;
  logic [NCH-1:0] rpCh_r;
  logic           rpFault_r;
  logic [2:0]     rpCount_r;
  logic [12:0]    rpWin_r;

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      dualCond[c] = (redEn & ~inhibit & chSw[c] &
                     ((grn[c] & yel[c]) | (grn[c] & red[c]) | (yel[c] & red[c])))
                  | (gyEn & ~inhibit & grn[c] & yel[c]);
    end
    dualOnset = dualCond & ~dualPrev_r;
  end

  // persistence timers and latched overlap channels
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dualPrev_r  <= '0;
      overlapCh_r <= '0;
      for (int c = 0; c < NCH; c++)
        dualCnt_r[c] <= 13'h0;
    end
    else
    begin
      dualPrev_r <= dualCond;
      for (int c = 0; c < NCH; c++)
      begin
        dualCnt_r[c] <= dualCond[c] ? tickUp(dualCnt_r[c], tick_r) : 13'h0;
        if (dualCond[c] && dualCnt_r[c] >= DUAL_TRIP)
          overlapCh_r[c] <= 1'b1;
        else if (rpFault_r && rpCh_r[c] && !resetCmd)
          overlapCh_r[c] <= 1'b1;
        else if (resetCmd)
          overlapCh_r[c] <= 1'b0;
      end
    end
  end

  // recurrent short overlap pulses within a window
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rpCount_r <= 3'h0;
      rpWin_r   <= 13'h0;
      rpFault_r <= 1'b0;
      rpCh_r    <= '0;
    end
    else
    begin
      if (|dualOnset)
      begin
        rpCount_r <= (rpCount_r == 3'h7) ? rpCount_r : rpCount_r + 3'h1;
        rpCh_r    <= rpCh_r | dualOnset;
      end
      else if (rpWin_r >= RP_WINDOW && !rpFault_r)
      begin
        rpCount_r <= 3'h0;
        rpCh_r    <= '0;
      end
      else if (resetCmd && rpCount_r >= RP_PULSES)
      begin
        rpCount_r <= 3'h0;
        rpCh_r    <= '0;
      end
      if (|dualOnset || rpWin_r >= RP_WINDOW)
        rpWin_r <= 13'h0;
      else
        rpWin_r <= tickUp(rpWin_r, tick_r);
      if (!rpDis && !rpFault_r && rpCount_r >= RP_PULSES)
        rpFault_r <= 1'b1;
      else if (resetCmd)
        rpFault_r <= 1'b0;
    end
  end

  // green to yellow to red sequence tracking
  sfm_seq_t       seqState_r [NCH];
  logic [12:0]    yelCnt_r   [NCH];
  logic [NCH-1:0] seqCh_r;
  logic [12:0]    clearTicks;

  assign clearTicks = yelClear(ySel);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seqCh_r <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        seqState_r[c] <= SFM_SEQ_IDLE;
        yelCnt_r[c]   <= 13'h0;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (!(redEn && !inhibit && chSw[c]))
          seqState_r[c] <= SFM_SEQ_IDLE;
        else
        begin
          unique case (seqState_r[c])
            SFM_SEQ_IDLE:
              if (grn[c] && !yel[c] && !red[c])
                seqState_r[c] <= SFM_SEQ_GREEN;
            SFM_SEQ_GREEN:
              if (yel[c] && !grn[c])
              begin
                seqState_r[c] <= SFM_SEQ_YEL;
                yelCnt_r[c]   <= 13'h0;
              end
              else if (red[c] && !grn[c])
                seqState_r[c] <= SFM_SEQ_IDLE;
            SFM_SEQ_YEL:
            begin
              yelCnt_r[c] <= tickUp(yelCnt_r[c], tick_r);
              if (!yel[c])
                seqState_r[c] <= grn[c] ? SFM_SEQ_GREEN : SFM_SEQ_IDLE;
            end
            default:
              seqState_r[c] <= SFM_SEQ_IDLE;
          endcase
        end
        // absent yellow, or red reached before the clearance ran out
        if (redEn && !inhibit && chSw[c] && red[c] && !yel[c] && !grn[c] &&
            ((seqState_r[c] == SFM_SEQ_GREEN) ||
             (seqState_r[c] == SFM_SEQ_YEL && yelCnt_r[c] < clearTicks)))
          seqCh_r[c] <= 1'b1;
        else if (resetCmd)
          seqCh_r[c] <= 1'b0;
      end
    end
  end

  // configuration compare, log and optional fault
  logic [CFG_W-1:0] storedCfg_r;
  logic             primed_r;
  logic [12:0]      cfgPeriod_r;
  logic [12:0]      holdCnt_r;
  logic             cfgFault_r;
  logic             cfgCheck, holdDone;

  assign cfgCheck = !primed_r || resetCmd || (cfgPeriod_r >= CFG_PERIOD);
  assign holdDone = cfgFault_r && cleanIn[POS_BTN] && holdCnt_r >= CFG_HOLD;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      storedCfg_r     <= '0;
      primed_r        <= 1'b0;
      cfgPeriod_r     <= 13'h0;
      holdCnt_r       <= 13'h0;
      cfgFault_r      <= 1'b0;
      configLogStrobe <= 1'b0;
      configLogWord   <= '0;
    end
    else
    begin
      primed_r        <= 1'b1;
      configLogStrobe <= 1'b0;
      cfgPeriod_r     <= (cfgPeriod_r >= CFG_PERIOD) ? 13'h0 : tickUp(cfgPeriod_r, tick_r);
      holdCnt_r       <= cleanIn[POS_BTN] ? tickUp(holdCnt_r, tick_r) : 13'h0;
      if (holdDone)
      begin
        cfgFault_r      <= 1'b0;
        storedCfg_r     <= cfgNow;
        configLogStrobe <= 1'b1;
        configLogWord   <= cfgNow;
      end
      else if (cfgCheck && cfgNow != storedCfg_r && !cfgFault_r)
      begin
        configLogStrobe <= 1'b1;
        configLogWord   <= cfgNow;
        if (cfgEn)
          cfgFault_r <= 1'b1;
        else
          storedCfg_r <= cfgNow;
      end
    end
  end

  // card ajar latch and review index
  logic       pcaFault_r;
  logic [1:0] reviewIdx_r;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcaFault_r  <= 1'b0;
      reviewIdx_r <= 2'h0;
    end
    else
    begin
      if (!card)
        pcaFault_r <= 1'b1;
      else if (resetCmd)
        pcaFault_r <= 1'b0;
      if (card)
        reviewIdx_r <= 2'h0;
      else if (resetCmd)
        reviewIdx_r <= (reviewIdx_r == HIST_LAST) ? 2'h0 : reviewIdx_r + 2'h1;
    end
  end

  // history of fault channels and field state; cleared only by core power
  logic [NCH-1:0]   tripCh, tripPrevCh_r;
  logic             tripped;
  logic [NCH-1:0]   histFlt_r [3];
  logic [3*NCH-1:0] histFld_r [3];

  assign tripCh  = overlapCh_r | seqCh_r;
  assign tripped = |tripCh | rpFault_r;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tripPrevCh_r <= '0;
      for (int i = 0; i < 3; i++)
      begin
        histFlt_r[i] <= '0;
        histFld_r[i] <= '0;
      end
    end
    else
    begin
      tripPrevCh_r <= tripCh;
      if (tripCh != tripPrevCh_r && (tripCh & ~tripPrevCh_r) != '0)
      begin
        if (tripPrevCh_r == '0)
        begin
          histFlt_r[2] <= histFlt_r[1];
          histFld_r[2] <= histFld_r[1];
          histFlt_r[1] <= histFlt_r[0];
          histFld_r[1] <= histFld_r[0];
          histFld_r[0] <= {red, yel, grn};
        end
        histFlt_r[0] <= tripCh;
      end
    end
  end

  // display timing, 4 Hz flash and card indicator blink phase
  logic [12:0] dispCnt_r;
  logic [12:0] flashCnt_r;
  logic        flash4_r;
  logic [3:0]  blinkPhase_r;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dispCnt_r    <= 13'h0;
      flashCnt_r   <= 13'h0;
      flash4_r     <= 1'b0;
      blinkPhase_r <= 4'h0;
    end
    else
    begin
      if (!(tripped || !card))
        dispCnt_r <= 13'h0;
      else if (tick_r)
        dispCnt_r <= (dispCnt_r >= DISP_CYCLE - 13'h1) ? 13'h0 : dispCnt_r + 13'h1;
      if (tick_r && flashCnt_r >= FLASH_HALF - 13'h1)
      begin
        flashCnt_r   <= 13'h0;
        flash4_r     <= ~flash4_r;
        blinkPhase_r <= (blinkPhase_r == BLINK_LAST) ? 4'h0 : blinkPhase_r + 4'h1;
      end
      else
        flashCnt_r <= tickUp(flashCnt_r, tick_r);
    end
  end

  // channel indicators and fault indicators
  logic [NCH-1:0]   selFlt;
  logic [3*NCH-1:0] selFld;

  assign selFlt = card ? tripCh : histFlt_r[reviewIdx_r];
  assign selFld = card ? histFld_r[0] : histFld_r[reviewIdx_r];

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dispGreen              <= '0;
      dispYellow             <= '0;
      dispRed                <= '0;
      colour_overlap_fault   <= 1'b0;
      sequenceFaultLed       <= 1'b0;
      recurrent_pulse_detect <= 1'b0;
      program_card_ajar      <= 1'b0;
    end
    else
    begin
      if (tripped || !card)
      begin
        if (dispCnt_r < FLT_SHOW)
        begin
          dispGreen  <= flash4_r ? selFlt : '0;
          dispYellow <= flash4_r ? selFlt : '0;
          dispRed    <= flash4_r ? selFlt : '0;
        end
        else
        begin
          dispGreen  <= selFld[POS_GRN +: NCH];
          dispYellow <= selFld[POS_YEL +: NCH];
          dispRed    <= selFld[POS_RED +: NCH];
        end
      end
      else
      begin
        dispGreen  <= grn;
        dispYellow <= yel;
        dispRed    <= red;
      end
      colour_overlap_fault   <= |overlapCh_r;
      sequenceFaultLed       <= |seqCh_r;
      recurrent_pulse_detect <= rpFault_r;
      if (!card)
        program_card_ajar <= !blinkPhase_r[0] &&
                             blinkPhase_r < {1'b0, reviewIdx_r, 1'b0} + 4'h2;
      else if (pcaFault_r)
        program_card_ajar <= 1'b1;
      else
        program_card_ajar <= cfgFault_r & flash4_r;
    end
  end

  // relay and stop-time sequencing
  sfm_relay_t  relayState_r;
  logic [12:0] exitCnt_r;
  logic        flashNeed;

  assign flashNeed = tripped | pcaFault_r | cfgFault_r | ~acGood;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      relayState_r <= SFM_FLASH;
      exitCnt_r    <= 13'h0;
      outputRelay  <= 1'b0;
      stopTime     <= 1'b1;
    end
    else
    begin
      unique case (relayState_r)
        SFM_FLASH:
        begin
          outputRelay <= 1'b0;
          stopTime    <= 1'b1;
          exitCnt_r   <= 13'h0;
          if (!flashNeed)
          begin
            relayState_r <= SFM_EXIT;
            stopTime     <= 1'b0;
          end
        end
        SFM_EXIT:
        begin
          exitCnt_r <= tickUp(exitCnt_r, tick_r);
          if (flashNeed)
          begin
            relayState_r <= SFM_FLASH;
            stopTime     <= 1'b1;
          end
          else if (exitCnt_r >= EXIT_LEAD)
          begin
            relayState_r <= SFM_RUN;
            outputRelay  <= 1'b1;
          end
        end
        SFM_RUN:
          if (flashNeed)
          begin
            relayState_r <= SFM_FLASH;
            outputRelay  <= 1'b0;
            stopTime     <= 1'b1;
          end
        default:
          relayState_r <= SFM_FLASH;
      endcase
    end
  end
endmodule

/* sfm_signal_fault_monitor_tb_top.sv */
/* bench: exit flash, overlap, short yellow, configuration change
   one ms is TK core_clk cycles; also recurrent pulse, brownout, card */
`timescale 1ns/1ps
module sfm_signal_fault_monitor_tb_top
  import sfm_pkg::*;
;
  localparam int unsigned TK = 4;
  logic             core_clk, reset_n, redEn, inhib, gyEn, rpDis, cfgEn, card, btn;
  logic             relay, stopT, ovl, seqF, rpLed, pcaLed, acOk, ext;
  logic [2:0]       aspect, ysel;
  logic [NCH-1:0]   chSw, gIn, yIn, rIn, dG, dY;
  logic [CFG_W-1:0] cfg, logW;
  int               fails = 0;
  int               nChecks = 0;
  sfm_field_model fld (.aspect(aspect), .greenIn(gIn), .yellowIn(yIn), .redIn(rIn));
  sfm_signal_fault_monitor #(.TICK_CYCLES(TK)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .greenIn(gIn), .yellowIn(yIn), .redIn(rIn),
    .redEnableIn(redEn), .external_inhibit_input(inhib), .acLineGood(acOk),
    .channel_check_switch(chSw), .green_yellow_overlap_enable(gyEn),
    .yellow_clearance_select(ysel), .recurrentPulseDisable(rpDis),
    .configFaultEnable(cfgEn), .configSettings(cfg), .cardSeated(card),
    .resetButton(btn), .externalResetIn(ext), .outputRelay(relay), .stopTime(stopT),
    .colour_overlap_fault(ovl), .sequenceFaultLed(seqF), .recurrent_pulse_detect(rpLed),
    .program_card_ajar(pcaLed), .dispGreen(dG), .dispYellow(dY), .dispRed(),
    .configLogStrobe(), .configLogWord(logW));
  // clock and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    #760_000;
    fails++;
    close_out;
  end
  task automatic ms(input int n);
    repeat (n * TK) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rstCmd;
    btn = 1'b1;
    ms(20);
    btn = 1'b0;
    ms(20);
  endtask
  task automatic seqRun(input int yms, input logic e);
    aspect = 3'h1;
    ms(20);
    aspect = 3'h2;
    ms(yms);
    aspect = 3'h4;
    ms(5);
    chk("seq", 32'(e), 32'(seqF));
    rstCmd;
    ms(300);
  endtask
  // main sequence
  initial
  begin
    {redEn, inhib, gyEn, rpDis, cfgEn, card, btn} = 7'h5e;
    {acOk, ext} = 2'h2;
    aspect = 3'h4;
    ysel = 3'h0;
    chSw = 16'h0001;
    cfg = 32'h0;
    reset_n = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 reset_n = 1'b1;
    ms(10);
    rstCmd;
    ms(160);
    chk("stop", 32'h0, 32'(stopT));
    chk("relay", 32'h0, 32'(relay));
    ms(100);
    chk("relay", 32'h1, 32'(relay));
    aspect = 3'h3;
    ms(200);
    aspect = 3'h1;
    ms(10);
    chk("ovl", 32'h0, 32'(ovl));
    inhib = 1'b1;
    aspect = 3'h3;
    ms(520);
    chk("ovl", 32'h0, 32'(ovl));
    inhib = 1'b0;
    ms(520);
    chk("ovl", 32'h1, 32'(ovl));
    chk("relay", 32'h0, 32'(relay));
    ms(2000);
    chk("disp", 32'h0001_0001, {dY, dG});
    aspect = 3'h1;
    rstCmd;
    ms(300);
    chk("relay", 32'h1, 32'(relay));
    seqRun(1000, 1'b1);
    ysel = 3'h1;
    seqRun(2850, 1'b1);
    seqRun(2950, 1'b0);
    cfg = 32'ha5;
    ms(1100);
    chk("log", 32'ha5, logW);
    chk("relay", 32'h0, 32'(relay));
    btn = 1'b1;
    ms(5100);
    btn = 1'b0;
    ms(300);
    chk("relay", 32'h1, 32'(relay));
    cfgEn = 1'b0;
    cfg = 32'h3c;
    ms(1100);
    chk("log", 32'h3c, logW);
    chk("relay", 32'h1, 32'(relay));
    // three short overlaps inside one window latch the recurrent pulse fault
    rpDis = 1'b0;
    repeat (3)
    begin
      aspect = 3'h3;
      ms(50);
      aspect = 3'h1;
      ms(50);
    end
    chk("rp", 32'h3, 32'({ovl, rpLed}));
    rstCmd;
    ms(300);
    chk("rp", 32'h1, 32'({ovl, rpLed, relay}));
    // brownout forces flash, restore exits without a reset command
    acOk = 1'b0;
    ms(20);
    chk("brown", 32'h2, 32'({stopT, relay}));
    acOk = 1'b1;
    ms(300);
    chk("brown", 32'h1, 32'(relay));
    // card pulled and reseated stays in flash until an external reset
    card = 1'b0;
    ms(20);
    card = 1'b1;
    ms(20);
    chk("card", 32'h6, 32'({pcaLed, stopT, relay}));
    ext = 1'b1;
    ms(20);
    ext = 1'b0;
    ms(300);
    chk("card", 32'h1, 32'({pcaLed, stopT, relay}));
    close_out;
  end
endmodule
bind sfm_signal_fault_monitor sfm_monitor_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .core_clk(core_clk), .reset_n(reset_n), .greenIn(greenIn), .yellowIn(yellowIn),
  .redIn(redIn), .recurrentPulseDisable(recurrentPulseDisable), .outputRelay(outputRelay),
  .stopTime(stopTime), .colour_overlap_fault(colour_overlap_fault),
  .sequenceFaultLed(sequenceFaultLed),
  .configLogWord(configLogWord), .configLogStrobe(configLogStrobe));
